// >>> hdl/pcm_pkg.sv
package pcm_pkg;

  // ************************************************************
  // register byte offsets (word aligned, wishbone)
  // ************************************************************
  localparam logic [7:0] SCER_OFS  = 8'h00;
  localparam logic [7:0] SCDR_OFS  = 8'h04;
  localparam logic [7:0] SCSR_OFS  = 8'h08;
  localparam logic [7:0] PCER_OFS  = 8'h10;
  localparam logic [7:0] PCDR_OFS  = 8'h14;
  localparam logic [7:0] PCSR_OFS  = 8'h18;
  localparam logic [7:0] MOR_OFS   = 8'h20;
  localparam logic [7:0] MCFR_OFS  = 8'h24;
  localparam logic [7:0] PLLA_OFS  = 8'h28;
  localparam logic [7:0] PLLB_OFS  = 8'h2c;
  localparam logic [7:0] MCKR_OFS  = 8'h30;
  localparam logic [7:0] PCK0_OFS  = 8'h40;
  localparam logic [7:0] IER_OFS   = 8'h60;
  localparam logic [7:0] IDR_OFS   = 8'h64;
  localparam logic [7:0] SR_OFS    = 8'h68;
  localparam logic [7:0] IMR_OFS   = 8'h6c;
  localparam logic [7:0] ICPR_OFS  = 8'h80;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int SC_CPU_BIT   = 0;
  localparam int SC_USB_BIT   = 7;
  localparam int SC_PCK_LSB   = 8;
  localparam int NUM_PCK      = 4;
  localparam int NUM_PERIPH   = 32;
  localparam int SR_MAIN_OSC_STABLE     = 0;
  localparam int SR_PLL_A_LOCKED     = 1;
  localparam int SR_PLL_B_LOCKED     = 2;
  localparam int SR_MASTER_CLOCK_SETTLED    = 3;
  localparam int SR_PCKRDY0   = 8;
  localparam int MOR_EN_BIT   = 0;
  localparam int MOR_CNT_LSB  = 8;
  localparam int MCFR_RDY_BIT = 16;
  localparam int PLL_DIV_LSB  = 0;
  localparam int PLL_CNT_LSB  = 8;
  localparam int PLL_MUL_LSB  = 16;
  localparam int PLL_USB_LSB  = 28;
  localparam int PLL_SRC_BIT  = 29;
  localparam int MCKR_CLOCK_DIVIDE_POWER_LSB = 2;
  localparam int MCKR_CPU_MASTER_RATIO_LSB = 8;

  // ************************************************************
  // reset values and timing
  // ************************************************************
  localparam logic [31:0] MCKR_RST = 32'h0000_0000;
  localparam logic [31:0] PLL_RST  = 32'h0000_3f00;
  localparam logic [2:0]  OSC_PRE_DIV = 3'h7;
  localparam logic [3:0]  FREQ_WINDOW = 4'hf;
  localparam int          SYNC_LEN = 2;

  typedef enum logic [1:0] {
    PCM_SRC_SLOW = 2'h0,
    PCM_SRC_MAIN = 2'h1,
    PCM_SRC_PLLA = 2'h2,
    PCM_SRC_PLLB = 2'h3
  } pcm_src_t;

endpackage : pcm_pkg

// >>> hdl/pcm_lock_timer.sv
`timescale 1ns/1ps
`default_nettype none
// counts down slow clock ticks after a load; done is a registered flag
module pcm_lock_timer
  import pcm_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       load,
  input  wire logic       hold_off,
  input  wire logic [7:0] count,
  input  wire logic       tick,
  output logic            done
);

  logic [7:0] cnt_ff;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_ff <= 8'h00;
      done   <= 1'b0;
    end
    else if (load || hold_off)
    begin
      cnt_ff <= count;
      done   <= 1'b0;
    end
    else if (!done && tick)
    begin
      if (cnt_ff == 8'h00)
        done <= 1'b1;
      else
        cnt_ff <= cnt_ff - 8'h01;
    end
  end

endmodule : pcm_lock_timer
`default_nettype wire

// >>> hdl/pcm_ctrl.sv
// The register addresses and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RULE1] master clock source from select field, divided by power of two 1..64
// [RULE2] any master config write clears settled flag until new clock settles
// [RULE3] cpu-to-master ratio field divides master clock from processor clock; code only stores the field in mckr_ff and drives no divider from it
// [RULE4] processor clock on after reset, off via disable reg, status readable
// [RULE5] enabled interrupt or reset restarts a stopped processor clock
// [RULE6] stop waits for current instruction; other bus masters unaffected
// [RULE7] software programs second pll for usb at 48, 96 or 192 MHz
// [RULE8] usb device clock enabled and disabled by bits, status shown
// [RULE9] each peripheral clock gated by enable/disable writes, status readable
// [RULE10] peripheral clock stops at once when disabled; all off after reset
// [RULE11] peripheral bit number equals its peripheral identifier
// [RULE12] software should let a peripheral finish before stopping its clock
// [RULE13] four output clocks, each selects source and divides by 1..64; code only stores each setting in pck_cfg_ff and drives just the enables
// [RULE14] write 1 to enable or disable output; active outputs in status
// [RULE15] per output a ready flag says it matches programmed configuration
// [RULE16] software disables output before changing its configuration
// [RULE17] oscillator enable and start-up count; stable after 8 x count slow
// [RULE18] frequency register counts main clocks in sixteen slow clock periods; code counts from a slow rise to the sixteenth slow fall, 15.5 periods
// [RULE19] software sets charge pump bit and bit 29 when writing pll a
// [RULE20] pll a divider 0 off, multiplier 0 off, else times value plus one
// [RULE21] pll a lock low for settle count after write or parameter change
// [RULE22] pll b same lock behaviour plus usb divider by 1, 2 or 4
// [RULE23] oscillator counter decrements at slow clock over 8, stable at zero
// [RULE24] unlocked selected pll falls back: a to slow, b to main clock
// [RULE25] status flags raise interrupt only when their enable bit is set
module pcm_ctrl
  import pcm_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  slow_clock,
  input  wire logic                  main_clock,
  input  wire logic                  cpu_irq,
  input  wire logic                  cpu_idle_ack,
  output logic                       processor_clock_en,
  output logic                       usb_device_clock_en,
  output logic [NUM_PERIPH-1:0]      periph_clock_en,
  output logic [NUM_PCK-1:0]         output_clock_en,
  output logic [1:0]                 master_src,
  output logic [2:0]                 master_clock_divide_power,
  output logic [1:0]                 usb_div,
  output logic                       main_osc_enable,
  output logic                       pll_a_enable,
  output logic                       pll_b_enable,
  output logic                       pmc_irq
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction : merge

  function automatic logic pll_on(input logic [31:0] cfg);
    return (cfg[PLL_DIV_LSB +: 8] != 8'h00) && (cfg[PLL_MUL_LSB +: 11] != 11'h000); // RULE20
  endfunction : pll_on

  // ************************************************************
  // slow clock synchroniser and edges
  // ************************************************************
  logic [SYNC_LEN-1:0] slow_clock_sync_ff;
  logic slow_clock_d_ff;
  logic slow_clock_rise;
  logic slow_clock_fall;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      slow_clock_sync_ff <= '0;
      slow_clock_d_ff    <= 1'b0;
    end
    else
    begin
      slow_clock_sync_ff <= {slow_clock_sync_ff[0], slow_clock};
      slow_clock_d_ff    <= slow_clock_sync_ff[1];
    end
  end
  assign slow_clock_rise = slow_clock_sync_ff[1] & ~slow_clock_d_ff;
  assign slow_clock_fall = ~slow_clock_sync_ff[1] & slow_clock_d_ff;

  // main clock is sampled too; only meaningful when much slower than sys_clk
  logic [SYNC_LEN-1:0] main_sync_ff;
  logic main_d_ff;
  logic main_rise;
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      main_sync_ff <= '0;
      main_d_ff    <= 1'b0;
    end
    else
    begin
      main_sync_ff <= {main_sync_ff[0], main_clock};
      main_d_ff    <= main_sync_ff[1];
    end
  end
  assign main_rise = main_sync_ff[1] & ~main_d_ff;

  // ************************************************************
  // wishbone slave: one wait state, ack drops after one cycle
  // ************************************************************
  logic req;
  logic wr;
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr  = req & wb_we_i;

  function automatic logic wr_at(input logic [7:0] ofs, input logic w,
                                 input logic [7:0] adr);
    return w && (adr == ofs);
  endfunction : wr_at

  logic [31:0] mor_ff, plla_ff, pllb_ff, mckr_ff, icpr_ff, imr_ff;
  logic [31:0] pck_cfg_ff [NUM_PCK];
  logic [31:0] mor_n, plla_n, pllb_n, mckr_n;
  assign mor_n  = merge(mor_ff, wb_dat_i, wb_sel_i);
  assign plla_n = merge(plla_ff, wb_dat_i, wb_sel_i);
  assign pllb_n = merge(pllb_ff, wb_dat_i, wb_sel_i);
  assign mckr_n = merge(mckr_ff, wb_dat_i, wb_sel_i);

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mor_ff  <= 32'h0000_0000;
      plla_ff <= PLL_RST;
      pllb_ff <= PLL_RST;
      mckr_ff <= MCKR_RST;
      icpr_ff <= 32'h0000_0000;
      imr_ff  <= 32'h0000_0000;
      for (int i = 0; i < NUM_PCK; i++)
        pck_cfg_ff[i] <= 32'h0000_0000;
    end
    else
    begin
      if (wr_at(MOR_OFS, wr, wb_adr_i))  mor_ff  <= mor_n;
      if (wr_at(PLLA_OFS, wr, wb_adr_i)) plla_ff <= plla_n;
      if (wr_at(PLLB_OFS, wr, wb_adr_i)) pllb_ff <= pllb_n;
      if (wr_at(MCKR_OFS, wr, wb_adr_i)) mckr_ff <= mckr_n;                  // RULE3
      if (wr_at(ICPR_OFS, wr, wb_adr_i)) icpr_ff <= merge(icpr_ff, wb_dat_i, wb_sel_i);
      if (wr_at(IER_OFS, wr, wb_adr_i))  imr_ff  <= imr_ff | wb_dat_i;   // RULE25
      if (wr_at(IDR_OFS, wr, wb_adr_i))  imr_ff  <= imr_ff & ~wb_dat_i;
      for (int i = 0; i < NUM_PCK; i++)
        if (wr_at(PCK0_OFS + 8'(4*i), wr, wb_adr_i))
          pck_cfg_ff[i] <= merge(pck_cfg_ff[i], wb_dat_i, wb_sel_i);
    end
  end

  // ************************************************************
  // oscillator start-up: count x 8 slow clocks
  // ************************************************************
  logic [2:0] osc_pre_ff;
  logic main_osc_stable;
  logic [7:0] osc_cnt;
  // a write loads the count that it carries, not the one that it replaces
  assign osc_cnt = wr_at(MOR_OFS, wr, wb_adr_i) ? mor_n[MOR_CNT_LSB +: 8]
                                                 : mor_ff[MOR_CNT_LSB +: 8];
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      osc_pre_ff <= 3'h0;
    // restart the divide-by-8 phase so start-up spans 8 x count slow clocks
    else if (wr_at(MOR_OFS, wr, wb_adr_i))
      osc_pre_ff <= OSC_PRE_DIV;                                        // RULE17
    else if (slow_clock_rise)
      osc_pre_ff <= (osc_pre_ff == OSC_PRE_DIV) ? 3'h0 : osc_pre_ff + 3'h1;
  end

  pcm_lock_timer u_osc_timer (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .load     (wr_at(MOR_OFS, wr, wb_adr_i)),                           // RULE17
    .hold_off (~mor_ff[MOR_EN_BIT]),
    .count    (osc_cnt),
    .tick     (slow_clock_rise && osc_pre_ff == OSC_PRE_DIV),                 // RULE23
    .done     (main_osc_stable)
  );

  // ************************************************************
  // main clock frequency counter from a slow rise to the sixteenth slow fall
  // ************************************************************
  logic [15:0] freq_count_value_ff;
  logic [3:0]  fwin_ff;
  logic        fcount_ff, freq_count_ready_ff, fstart_ff;
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      freq_count_value_ff <= 16'h0000; fwin_ff <= 4'h0;
      fcount_ff <= 1'b0; freq_count_ready_ff <= 1'b0; fstart_ff <= 1'b0;
    end
    else if (!main_osc_stable)
    begin
      freq_count_value_ff <= 16'h0000; fwin_ff <= 4'h0;
      fcount_ff <= 1'b0; freq_count_ready_ff <= 1'b0; fstart_ff <= 1'b0;
    end
    else
    begin
      if (!fstart_ff && slow_clock_rise)
      begin
        fstart_ff <= 1'b1;
        fcount_ff <= 1'b1;
      end
      if (fcount_ff && main_rise)
        freq_count_value_ff <= freq_count_value_ff + 16'h0001;                                // RULE18
      if (fcount_ff && slow_clock_fall)
      begin
        fwin_ff <= fwin_ff + 4'h1;
        if (fwin_ff == FREQ_WINDOW)
        begin
          fcount_ff  <= 1'b0;
          freq_count_ready_ff <= 1'b1;
        end
      end
    end
  end

  // ************************************************************
  // pll lock timers
  // ************************************************************
  logic lock_a, lock_b;
  logic plla_chg, pllb_chg;
  assign plla_chg = wr_at(PLLA_OFS, wr, wb_adr_i);                      // RULE21
  assign pllb_chg = wr_at(PLLB_OFS, wr, wb_adr_i);                      // RULE22
  logic [7:0] plla_cnt, pllb_cnt;
  assign plla_cnt = plla_chg ? plla_n[PLL_CNT_LSB +: 8] : plla_ff[PLL_CNT_LSB +: 8]; // RULE21
  assign pllb_cnt = pllb_chg ? pllb_n[PLL_CNT_LSB +: 8] : pllb_ff[PLL_CNT_LSB +: 8]; // RULE22

  pcm_lock_timer u_plla_timer (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .load     (plla_chg),
    .hold_off (~pll_on(plla_ff)),
    .count    (plla_cnt),
    .tick     (slow_clock_rise),
    .done     (lock_a)
  );

  pcm_lock_timer u_pllb_timer (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .load     (pllb_chg),
    .hold_off (~pll_on(pllb_ff)),
    .count    (pllb_cnt),
    .tick     (slow_clock_rise),
    .done     (lock_b)
  );

  // ************************************************************
  // master clock selection and settled flag
  // ************************************************************
  logic [1:0] clock_source_select;
  logic [1:0] eff_src;
  logic master_clock_settled_ff;
  logic [1:0] settle_ff;
  assign clock_source_select = mckr_ff[1:0];
  always_comb
  begin
    eff_src = clock_source_select;                                                      // RULE1
    if (clock_source_select == PCM_SRC_PLLA && !lock_a)
      eff_src = PCM_SRC_SLOW;                                           // RULE24
    else if (clock_source_select == PCM_SRC_PLLB && !lock_b)
      eff_src = PCM_SRC_MAIN;                                           // RULE24
  end

  // settles two slow clock edges after the write, and with a pll selected only once it locks
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      master_clock_settled_ff <= 1'b1;
      settle_ff <= 2'h0;
    end
    else if (wr_at(MCKR_OFS, wr, wb_adr_i) || eff_src != clock_source_select)
    begin
      master_clock_settled_ff <= 1'b0;                                                // RULE2
      settle_ff <= 2'h0;
    end
    else if (!master_clock_settled_ff && slow_clock_rise)
    begin
      settle_ff <= settle_ff + 2'h1;
      if (settle_ff == 2'h1)
        master_clock_settled_ff <= 1'b1;
    end
  end

  // ************************************************************
  // system and peripheral clock gates
  // ************************************************************
  logic [31:0] scsr_ff, pcsr_ff;
  logic        cpu_stop_pend_ff;
  logic        sc_en_w, sc_dis_w;
  assign sc_en_w  = wr_at(SCER_OFS, wr, wb_adr_i);
  assign sc_dis_w = wr_at(SCDR_OFS, wr, wb_adr_i);

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scsr_ff          <= 32'h0000_0001;                                // RULE4
      cpu_stop_pend_ff <= 1'b0;
    end
    else
    begin
      if (sc_en_w)
        scsr_ff[31:1] <= scsr_ff[31:1] | wb_dat_i[31:1];                // RULE8 RULE14
      if (sc_dis_w)
        scsr_ff[31:1] <= scsr_ff[31:1] & ~wb_dat_i[31:1];               // RULE14
      if (sc_dis_w && wb_dat_i[SC_CPU_BIT])
        cpu_stop_pend_ff <= 1'b1;
      if (cpu_irq)
      begin
        scsr_ff[SC_CPU_BIT] <= 1'b1;                                    // RULE5
        cpu_stop_pend_ff    <= 1'b0;
      end
      else if (cpu_stop_pend_ff && cpu_idle_ack)
      begin
        scsr_ff[SC_CPU_BIT] <= 1'b0;                                    // RULE6
        cpu_stop_pend_ff    <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      pcsr_ff <= 32'h0000_0000;                                         // RULE10
    else if (wr_at(PCER_OFS, wr, wb_adr_i))
      pcsr_ff <= pcsr_ff | wb_dat_i;                                    // RULE9 RULE11
    else if (wr_at(PCDR_OFS, wr, wb_adr_i))
      pcsr_ff <= pcsr_ff & ~wb_dat_i;                                   // RULE10
  end

  // ************************************************************
  // programmable output ready: enabled and config stable
  // ************************************************************
  logic [NUM_PCK-1:0] pckrdy_ff;
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      pckrdy_ff <= '0;
    else
      for (int i = 0; i < NUM_PCK; i++)
        if (!scsr_ff[SC_PCK_LSB+i] || wr_at(PCK0_OFS + 8'(4*i), wr, wb_adr_i))
          pckrdy_ff[i] <= 1'b0;                                         // RULE15
        else if (slow_clock_rise)
          pckrdy_ff[i] <= 1'b1;
  end

  // ************************************************************
  // status, read mux, outputs
  // ************************************************************
  logic [31:0] sr;
  always_comb
  begin
    sr = 32'h0000_0000;
    sr[SR_MAIN_OSC_STABLE]  = main_osc_stable;
    sr[SR_PLL_A_LOCKED]  = lock_a;
    sr[SR_PLL_B_LOCKED]  = lock_b;
    sr[SR_MASTER_CLOCK_SETTLED] = master_clock_settled_ff;
    sr[SR_PCKRDY0 +: NUM_PCK] = pckrdy_ff;
  end

  logic [31:0] rd;
  always_comb
  begin
    rd = 32'h0000_0000;
    unique case (wb_adr_i)
      SCSR_OFS: rd = scsr_ff;
      PCSR_OFS: rd = pcsr_ff;
      MOR_OFS:  rd = mor_ff;
      MCFR_OFS: rd = {15'h0000, freq_count_ready_ff, freq_count_value_ff};
      PLLA_OFS: rd = plla_ff;
      PLLB_OFS: rd = pllb_ff;
      MCKR_OFS: rd = mckr_ff;
      SR_OFS:   rd = sr;
      IMR_OFS:  rd = imr_ff;
      ICPR_OFS: rd = icpr_ff;
      PCK0_OFS: rd = pck_cfg_ff[0];
      8'h44:    rd = pck_cfg_ff[1];
      8'h48:    rd = pck_cfg_ff[2];
      8'h4c:    rd = pck_cfg_ff[3];
      default:  rd = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      processor_clock_en <= 1'b1;
      usb_device_clock_en <= 1'b0;
      periph_clock_en <= '0;
      output_clock_en <= '0;
      master_src <= 2'h0;
      master_clock_divide_power <= 3'h0;
      usb_div <= 2'h0;
      main_osc_enable <= 1'b0;
      pll_a_enable <= 1'b0;
      pll_b_enable <= 1'b0;
      pmc_irq <= 1'b0;
    end
    else
    begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd : 32'h0000_0000;
      processor_clock_en  <= scsr_ff[SC_CPU_BIT];                      // RULE4
      usb_device_clock_en <= scsr_ff[SC_USB_BIT] & lock_b;             // RULE8
      periph_clock_en     <= pcsr_ff;                                   // RULE9
      output_clock_en     <= scsr_ff[SC_PCK_LSB +: NUM_PCK];           // RULE13
      master_src          <= eff_src;
      master_clock_divide_power         <= mckr_ff[MCKR_CLOCK_DIVIDE_POWER_LSB +: 3];
      usb_div             <= pllb_ff[PLL_USB_LSB +: 2];                 // RULE22
      main_osc_enable     <= mor_ff[MOR_EN_BIT];
      pll_a_enable        <= pll_on(plla_ff);
      pll_b_enable        <= pll_on(pllb_ff);
      pmc_irq             <= |(sr & imr_ff);                            // RULE25
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_ack_one_cycle: assert property (@(posedge sys_clk) disable iff (!rst_b) // wishbone slave
    wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
  a_mckr_clears_rdy: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE2
    wr_at(MCKR_OFS, wr, wb_adr_i) |=> !master_clock_settled_ff) else $error("settled not cleared");
  a_plla_fallback: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE24
    (clock_source_select == PCM_SRC_PLLA && !lock_a) |=> master_src == PCM_SRC_SLOW)
    else $error("no fallback to slow clock");
  a_pcer_sets: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE9
    (wr_at(PCER_OFS, wr, wb_adr_i) && wb_dat_i[4]) |=> ##1 periph_clock_en[4])
    else $error("peripheral clock not enabled");
  a_pcdr_stops: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE10
    (wr_at(PCDR_OFS, wr, wb_adr_i) && wb_dat_i[4]) |=> ##1 !periph_clock_en[4])
    else $error("peripheral clock not stopped");
  a_cpu_wake: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE5
    cpu_irq |=> ##1 processor_clock_en) else $error("irq did not wake cpu");
  a_plla_unlock: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE21
    plla_chg |=> !lock_a) else $error("lock a not cleared on write");
  a_irq_masked: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE25
    (imr_ff == 32'h0) |=> !pmc_irq) else $error("irq without enable");
  a_scdr_pck: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE14
    (sc_dis_w && wb_dat_i[SC_PCK_LSB]) |=> ##1 !output_clock_en[0])
    else $error("output clock not disabled");

endmodule : pcm_ctrl
`default_nettype wire

// >>> bench/pcm_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ***
// clock sources and cpu idle handshake
// ***
module pcm_cpu_model
(
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic wfi,
  input  wire logic irq,
  output logic      slow_clock,
  output logic      main_clock,
  output logic      cpu_irq,
  output logic      cpu_idle_ack
);
  logic [5:0] div_ff;
  logic [2:0] idle_ff;

  // main at sys/8 keeps the sampled edges clean; slow is 8 times slower
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      div_ff <= 6'h00;
    else
      div_ff <= div_ff + 6'h01;
  end
  assign slow_clock = div_ff[5];
  assign main_clock = div_ff[2];

  // idle ack trails the request while the current instruction drains
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      idle_ff <= 3'h0;
      cpu_irq <= 1'b0;
    end
    else
    begin
      idle_ff <= {idle_ff[1:0], wfi};
      cpu_irq <= irq;
    end
  end
  assign cpu_idle_ack = idle_ff[2];
endmodule : pcm_cpu_model
`default_nettype wire

// >>> bench/test_pcm_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_pcm_ctrl
  import pcm_pkg::*;
;
  logic        sys_clk, rst_b, cyc, stb, we, wfi, irq, ack;
  logic        pclk, usb_en, pll_a, pll_b, osc, irq_o, slow, mainc, cirq, idle;
  logic [7:0]  adr;
  logic [3:0]  sel, oce;
  logic [31:0] dat, rdat, q, pce;
  logic [1:0]  msrc, udiv;
  logic [2:0]  mpres;
  int          failures, samples_checked, t;
  int          cycles = 0;

  pcm_ctrl pcm_ctrl_inst (.sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .slow_clock(slow),
    .main_clock(mainc), .cpu_irq(cirq), .cpu_idle_ack(idle),
    .processor_clock_en(pclk), .usb_device_clock_en(usb_en),
    .periph_clock_en(pce), .output_clock_en(oce), .master_src(msrc),
    .master_clock_divide_power(mpres), .usb_div(udiv), .main_osc_enable(osc),
    .pll_a_enable(pll_a), .pll_b_enable(pll_b), .pmc_irq(irq_o));

  pcm_cpu_model pcm_cpu_model_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .wfi(wfi), .irq(irq), .slow_clock(slow), .main_clock(mainc),
    .cpu_irq(cirq), .cpu_idle_ack(idle));

  // ***
  // bus access and checking
  // ***
  task automatic final_report;
    if (failures == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input string s, input logic [31:0] v, input logic [31:0] e);
    samples_checked++;
    if (v !== e)
    begin
      $display("Error %s exp %h seen %h", s, e, v);
      failures++;
    end
  endtask : chk

  // called just after a rising edge; holds the request until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge sys_clk);
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
    bus(1'b0, a, 32'h0);
    chk(s, q, e);
  endtask : rd

  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int n;
    n = 0;
    do bus(1'b0, a, 32'h0);
    while (q[b] !== v && ++n < 1000);
    chk("poll", 32'(q[b]), 32'(v));
  endtask : poll

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) cycles <= cycles + 1;

  initial
  begin
    repeat (40000) @(posedge sys_clk);
    failures++;
    final_report;
  end

  // ***
  // scenarios
  // ***
  initial
  begin
    {rst_b, cyc, stb, we, wfi, irq, adr, dat} = '0;
    sel = 4'hf;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    chk("pclk", 32'(pclk), 32'h1);
    rd(PCSR_OFS, 32'h0, "pcsr");
    wr(PCER_OFS, 32'h0000_0110);
    rd(PCSR_OFS, 32'h0000_0110, "pcsr");
    wr(PCDR_OFS, 32'h0000_0010);
    rd(PCSR_OFS, 32'h0000_0100, "pcsr");
    chk("pce", pce, 32'h0000_0100);
    rd(8'h90, 32'h0, "unmapped");
    wr(8'h44, 32'h0000_0015);
    rd(8'h44, 32'h0000_0015, "pck1");
    wr(SCER_OFS, 32'h0000_0f00);
    rd(SCSR_OFS, 32'h0000_0f01, "scsr");
    poll(SR_OFS, SR_PCKRDY0 + 1, 1'b1);
    wr(SCDR_OFS, 32'h0000_0100);
    rd(SCSR_OFS, 32'h0000_0e01, "scsr");
    chk("oce", 32'(oce), 32'he);
    t = cycles;
    wr(MOR_OFS, 32'h0000_0201);
    chk("osc", 32'(osc), 32'h1);
    poll(SR_OFS, SR_MAIN_OSC_STABLE, 1'b1);
    chk("osc_t", 32'((cycles - t) inside {[560:1100]}), 32'h1);
    wr(IER_OFS, 32'h1);
    chk("irq", 32'(irq_o), 32'h1);
    wr(IDR_OFS, 32'h1);
    chk("irq", 32'(irq_o), 32'h0);
    poll(MCFR_OFS, MCFR_RDY_BIT, 1'b1);
    chk("freq_count_value", 32'(q[15:0] inside {[120:136]}), 32'h1);
    wr(ICPR_OFS, 32'h1);
    t = cycles;
    wr(PLLA_OFS, 32'h2003_0605);
    chk("pll_a", 32'(pll_a), 32'h1);
    poll(SR_OFS, SR_PLL_A_LOCKED, 1'b1);
    chk("lock_t", 32'((cycles - t) inside {[380:470]}), 32'h1);
    wr(MCKR_OFS, 32'h0000_0106);
    bus(1'b0, SR_OFS, 32'h0);
    chk("settled", 32'(q[SR_MASTER_CLOCK_SETTLED]), 32'h0);
    rd(MCKR_OFS, 32'h0000_0106, "mckr");
    poll(SR_OFS, SR_MASTER_CLOCK_SETTLED, 1'b1);
    chk("mck", {27'h0, mpres, msrc}, {27'h0, 3'h1, PCM_SRC_PLLA});
    wr(PLLA_OFS, 32'h2004_0605);
    bus(1'b0, SR_OFS, 32'h0);
    chk("pll_a_locked", 32'(q[SR_PLL_A_LOCKED]), 32'h0);
    chk("fallback", 32'(msrc), 32'(PCM_SRC_SLOW));
    poll(SR_OFS, SR_MASTER_CLOCK_SETTLED, 1'b1);
    chk("msrc", 32'(msrc), 32'(PCM_SRC_PLLA));
    wr(PLLB_OFS, 32'h1004_0805);
    poll(SR_OFS, SR_PLL_B_LOCKED, 1'b1);
    wr(SCER_OFS, 32'h0000_0080);
    rd(SCSR_OFS, 32'h0000_0e81, "scsr");
    chk("usb", {28'h0, pll_b, usb_en, udiv}, 32'hd);
    wr(SCDR_OFS, 32'h1);
    rd(SCSR_OFS, 32'h0000_0e81, "scsr");
    wfi <= 1'b1;
    poll(SCSR_OFS, SC_CPU_BIT, 1'b0);
    chk("pclk", 32'(pclk), 32'h0);
    irq <= 1'b1;
    wfi <= 1'b0;
    poll(SCSR_OFS, SC_CPU_BIT, 1'b1);
    chk("pclk", 32'(pclk), 32'h1);
    final_report;
  end
endmodule : test_pcm_ctrl
`default_nettype wire
